// File: hw/prl_periph_req.sv
// peripheral request servicing for one interface of a programmable dma controller
// assumes the channel thread holds a command until cmd_done, and axi beats are sampled here
`timescale 1ns/1ps
module prl_periph_req #(
   parameter int FIFO_DEPTH = prl_pkg::FIFO_DEPTH_DEF
) (
   input wire logic CLK_IN,
   input wire logic SRST_IN,
   // peripheral side
   input wire logic REQ_VALID_IN,
   input wire logic [1:0] REQ_TYPE_IN,
   input wire logic REQ_LAST_IN,
   output logic REQ_READY_OUT,
   output logic ACK_VALID_OUT,
   output logic [1:0] ACK_TYPE_OUT,
   input wire logic ACK_READY_IN,
   // channel thread side
   input wire prl_pkg::prl_cmd_type CMD_IN,
   input wire logic CMD_VALID_IN,
   output logic CMD_DONE_OUT,
   output logic REQ_TYPE_FLAG_OUT,
   output logic REQ_LAST_FLAG_OUT,
   input wire logic FINAL_SINGLE_IN,
   // axi master observation
   input wire logic RVALID_IN,
   input wire logic RREADY_IN,
   input wire logic RLAST_IN,
   input wire logic BVALID_IN,
   input wire logic BREADY_IN
);
   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   logic [3:0] sync1_r;
   logic [3:0] sync2_r;
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= {REQ_VALID_IN, REQ_TYPE_IN, REQ_LAST_IN};
         sync2_r <= sync1_r;
      end
   end
   wire req_valid_s = sync2_r[3];
   wire [1:0] req_type_s = sync2_r[2:1];
   wire req_last_s = sync2_r[0];

   // ---------------------------------------------------------------
   // request queue
   // ---------------------------------------------------------------
   typedef enum {ST_IDLE, ST_WAIT, ST_XFER, ST_ACK, ST_FLUSHWAIT} prl_state_type;
   prl_state_type state_r;
   prl_state_type state_nxt;
   logic flushing_r;
   logic type_flag_r;
   logic last_flag_r;
   logic ack_valid_r;
   logic [1:0] ack_type_r;
   logic [1:0] ack_type_nxt;
   logic done_r;
   prl_pkg::prl_req_type head;
   logic empty;
   logic full;
   prl_pkg::prl_req_type push_data;

   assign push_data.burst = (req_type_s == prl_pkg::REQ_BURST);
   assign push_data.last = req_last_s;
   // ready only when room is left and no flush is pending
   assign REQ_READY_OUT = !full && !flushing_r;
   wire req_take = req_valid_s && REQ_READY_OUT;
   wire req_ok = (req_type_s == prl_pkg::REQ_SINGLE) || (req_type_s == prl_pkg::REQ_BURST);
   wire push = req_take && req_ok;
   wire flush_ack = req_valid_s && flushing_r && (req_type_s == prl_pkg::REQ_FLUSH_ACK);
   wire cmd_go = CMD_VALID_IN && (state_r == ST_IDLE) && !done_r;
   wire flush_cmd = cmd_go && CMD_IN.flush;
   wire in_wait = (state_r == ST_WAIT);
   // wait-any pops only singles; a burst head stays put
   wire pop_wait_any = in_wait && CMD_IN.wait_any && !empty && !head.burst;
   // wait-burst discards singles and pops the burst
   wire pop_wait_burst = in_wait && CMD_IN.wait_burst && !empty;
   wire pop = pop_wait_any || pop_wait_burst;
   wire wait_hit = in_wait && !empty && (CMD_IN.wait_any || head.burst);

   prl_req_fifo #(
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_in(CLK_IN),
      .srst_in(SRST_IN),
      .clear_in(flush_cmd),
      .push_in(push),
      .push_data_in(push_data),
      .pop_in(pop),
      .head_out(head),
      .empty_out(empty),
      .full_out(full)
   );

   // ---------------------------------------------------------------
   // transfer completion and acknowledge selection
   // ---------------------------------------------------------------
   wire rd_done = RVALID_IN && RREADY_IN && RLAST_IN;
   wire wr_done = BVALID_IN && BREADY_IN;
   wire xfer_done = (CMD_IN.load_ack && rd_done) || (CMD_IN.store_ack && wr_done);
   wire ack_take = ACK_VALID_OUT && ACK_READY_IN;
   // a flush request handed over also waits for the peripheral's answer
   wire flush_req_sent = ack_take && (ack_type_r == prl_pkg::ACK_FLUSH_REQ);
   // burst served as singles: each ack is single, the last asks for a flush
   wire [1:0] xfer_ack_type = CMD_IN.serve_single ?
      (FINAL_SINGLE_IN ? prl_pkg::ACK_FLUSH_REQ : prl_pkg::ACK_SINGLE) :
      (type_flag_r ? prl_pkg::ACK_BURST : prl_pkg::ACK_SINGLE);

   // ---------------------------------------------------------------
   // command sequencer
   // ---------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      ack_type_nxt = ack_type_r;
      case (state_r)
         ST_IDLE: begin
            if (cmd_go) begin
               if (CMD_IN.wait_any || CMD_IN.wait_burst || CMD_IN.wait_single) begin
                  state_nxt = ST_WAIT;
               end else if (CMD_IN.load_ack || CMD_IN.store_ack) begin
                  state_nxt = ST_XFER;
               end else if (CMD_IN.flush) begin
                  state_nxt = ST_FLUSHWAIT;
               end
            end
         end
         ST_WAIT: begin
            if (wait_hit) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_XFER: begin
            if (xfer_done) begin
               ack_type_nxt = xfer_ack_type;
               state_nxt = ST_ACK;
            end
         end
         ST_ACK: begin
            if (ack_take) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_FLUSHWAIT: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         state_r <= ST_IDLE;
         ack_type_r <= prl_pkg::ACK_SINGLE;
         ack_valid_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         ack_type_r <= ack_type_nxt;
         ack_valid_r <= (state_nxt == ST_ACK);
         // done pulses when a command finishes; the thread drops valid then
         done_r <= (state_r != ST_IDLE) && (state_nxt == ST_IDLE);
      end
   end

   // ---------------------------------------------------------------
   // flush tracking and request flags
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         flushing_r <= 1'b0;
         type_flag_r <= 1'b0;
         last_flag_r <= 1'b0;
      end else begin
         // a new flush command outranks a stale answer in the same cycle
         if (flush_cmd || flush_req_sent) begin
            flushing_r <= 1'b1;
         end else if (flush_ack) begin
            flushing_r <= 1'b0;
         end
         if (wait_hit) begin
            if (CMD_IN.wait_any) begin
               type_flag_r <= head.burst;
               last_flag_r <= head.last;
            end else begin
               type_flag_r <= 1'b1;
               last_flag_r <= 1'b0;
            end
         end
         if (cmd_go && CMD_IN.wait_single) begin
            type_flag_r <= 1'b0;
            last_flag_r <= 1'b0;
         end
      end
   end

   assign ACK_VALID_OUT = ack_valid_r;
   assign ACK_TYPE_OUT = ack_type_r;
   assign CMD_DONE_OUT = done_r;
   assign REQ_TYPE_FLAG_OUT = type_flag_r;
   assign REQ_LAST_FLAG_OUT = last_flag_r;
endmodule : prl_periph_req

// File: hw/prl_pkg.sv
// shared types and constants for the peripheral request servicing block
// assumes a single clock domain; no software-visible registers
package prl_pkg;
   // request type encodings on the request-type bus
   localparam logic [1:0] REQ_SINGLE = 2'h0;
   localparam logic [1:0] REQ_BURST = 2'h1;
   localparam logic [1:0] REQ_FLUSH_ACK = 2'h2;
   // acknowledge type encodings on the acknowledge-type bus
   localparam logic [1:0] ACK_SINGLE = 2'h0;
   localparam logic [1:0] ACK_BURST = 2'h1;
   localparam logic [1:0] ACK_FLUSH_REQ = 2'h2;
   localparam int FIFO_DEPTH_DEF = 4;

   // one queued request: type bit and last flag
   typedef struct packed {
      logic burst;
      logic last;
   } prl_req_type;

   // instruction issued by the channel thread
   typedef struct packed {
      logic wait_single;
      logic wait_burst;
      logic wait_any;
      logic load_ack;
      logic store_ack;
      logic flush;
      logic serve_single;
   } prl_cmd_type;
endpackage : prl_pkg

// File: hw/prl_req_fifo.sv
// request queue for one peripheral interface, flip-flop storage
// assumes push and pop come from logic on the same clock
`timescale 1ns/1ps
module prl_req_fifo #(
   parameter int DEPTH = prl_pkg::FIFO_DEPTH_DEF
) (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic clear_in,
   input wire logic push_in,
   input wire prl_pkg::prl_req_type push_data_in,
   input wire logic pop_in,
   output prl_pkg::prl_req_type head_out,
   output logic empty_out,
   output logic full_out
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
   prl_pkg::prl_req_type mem_r [DEPTH];
   logic [AW-1:0] rd_r;
   logic [AW-1:0] wr_r;
   logic [AW:0] cnt_r;
   wire do_push = push_in && !full_out;
   wire do_pop = pop_in && !empty_out;
   wire [AW-1:0] rd_inc = (rd_r == LAST_IDX) ? '0 : rd_r + 1'b1;
   wire [AW-1:0] wr_inc = (wr_r == LAST_IDX) ? '0 : wr_r + 1'b1;

   assign empty_out = (cnt_r == '0);
   assign full_out = (cnt_r == DEPTH_C);
   assign head_out = mem_r[rd_r];

   always_ff @(posedge clk_in) begin
      if (srst_in || clear_in) begin
         rd_r <= '0;
         wr_r <= '0;
         cnt_r <= '0;
      end else begin
         if (do_push) begin
            mem_r[wr_r] <= push_data_in;
            wr_r <= wr_inc;
         end
         if (do_pop) begin
            rd_r <= rd_inc;
         end
         cnt_r <= cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end
endmodule : prl_req_fifo

// File: dv/prl_periph_req_asserts.sv
// port checker for prl_periph_req, bound to every instance
// assumes the thread holds each command until done
`timescale 1ns/1ps
module prl_periph_req_asserts (
   input wire logic CLK_IN,
   input wire logic SRST_IN,
   input wire logic REQ_READY_OUT,
   input wire logic ACK_VALID_OUT,
   input wire logic [1:0] ACK_TYPE_OUT,
   input wire logic ACK_READY_IN,
   input wire prl_pkg::prl_cmd_type CMD_IN,
   input wire logic CMD_VALID_IN,
   input wire logic CMD_DONE_OUT,
   input wire logic REQ_TYPE_FLAG_OUT,
   input wire logic FINAL_SINGLE_IN,
   input wire logic RVALID_IN,
   input wire logic RREADY_IN,
   input wire logic RLAST_IN,
   input wire logic BVALID_IN,
   input wire logic BREADY_IN
);
   default clocking dc @(posedge CLK_IN);
   endclocking
   default disable iff (SRST_IN);
   AST_ACK_HOLD: assert property (ACK_VALID_OUT && !ACK_READY_IN
      |=> ACK_VALID_OUT && $stable(ACK_TYPE_OUT)) else $error("ack dropped early");
   AST_DONE_PULSE: assert property (CMD_DONE_OUT |=> !CMD_DONE_OUT)
      else $error("done wider than one cycle");
   AST_WR_ACK: assert property (CMD_VALID_IN && $past(CMD_VALID_IN) && CMD_IN.store_ack
      && BVALID_IN && BREADY_IN |=> ACK_VALID_OUT) else $error("no write ack");
   AST_RD_ACK: assert property (CMD_VALID_IN && $past(CMD_VALID_IN) && CMD_IN.load_ack
      && RVALID_IN && RREADY_IN && RLAST_IN |=> ACK_VALID_OUT) else $error("no read ack");
   AST_ACK_DONE: assert property (ACK_VALID_OUT && ACK_READY_IN
      |=> !ACK_VALID_OUT && CMD_DONE_OUT) else $error("ack handshake wrong");
   AST_FLUSH: assert property ($rose(CMD_VALID_IN) && CMD_IN.flush
      |=> !REQ_READY_OUT ##1 CMD_DONE_OUT) else $error("flush sequence wrong");
   AST_BURST_FLAG: assert property (CMD_DONE_OUT && CMD_VALID_IN && CMD_IN.wait_burst
      |-> ##[0:1] REQ_TYPE_FLAG_OUT) else $error("burst wait without burst flag");
   AST_SERVE_TYPE: assert property ($rose(ACK_VALID_OUT) && CMD_IN.serve_single
      |-> ACK_TYPE_OUT == (FINAL_SINGLE_IN ? prl_pkg::ACK_FLUSH_REQ : prl_pkg::ACK_SINGLE))
      else $error("single serve ack type wrong");
   AST_BURST_ACK: assert property ($rose(ACK_VALID_OUT) && !CMD_IN.serve_single
      |-> ACK_TYPE_OUT == {1'b0, REQ_TYPE_FLAG_OUT}) else $error("ack type off flag");
endmodule : prl_periph_req_asserts
bind prl_periph_req prl_periph_req_asserts prl_periph_req_asserts_i (.CLK_IN(CLK_IN),
   .SRST_IN(SRST_IN), .REQ_READY_OUT(REQ_READY_OUT), .ACK_VALID_OUT(ACK_VALID_OUT),
   .ACK_TYPE_OUT(ACK_TYPE_OUT), .ACK_READY_IN(ACK_READY_IN), .CMD_IN(CMD_IN),
   .CMD_VALID_IN(CMD_VALID_IN), .CMD_DONE_OUT(CMD_DONE_OUT), .FINAL_SINGLE_IN(FINAL_SINGLE_IN),
   .REQ_TYPE_FLAG_OUT(REQ_TYPE_FLAG_OUT), .RVALID_IN(RVALID_IN), .RREADY_IN(RREADY_IN),
   .RLAST_IN(RLAST_IN), .BVALID_IN(BVALID_IN), .BREADY_IN(BREADY_IN));

// File: dv/prl_periph_model.sv
// peripheral model: queued requests, ack capture, flush answer
// assumes the bench fills tx_q; entry = type*2+last, 4 = flush ack
`timescale 1ns/1ps
module prl_periph_model (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic slow_in,
   input wire logic req_ready_in,
   input wire logic ack_valid_in,
   input wire logic [1:0] ack_type_in,
   output logic req_valid_out = 1'b0,
   output logic [1:0] req_type_out = 2'h0,
   output logic req_last_out = 1'b0,
   output logic ack_ready_out = 1'b0
);
   int tx_q[$];
   logic [1:0] rx_q[$];
   logic burst_open = 1'b0;
   int gap = 0;
   int v;
   always @(posedge clk_in) begin
      req_valid_out <= 1'b0;
      // released lines toggle so stale values never look valid
      req_type_out <= ~req_type_out;
      req_last_out <= ~req_last_out;
      ack_ready_out <= slow_in ? 1'($urandom) : 1'b1;
      if (gap > 0) gap <= gap - 1;
      if (ack_valid_in && ack_ready_out) begin
         rx_q.push_back(ack_type_in);
         if (ack_type_in != prl_pkg::ACK_SINGLE) burst_open <= 1'b0;
         if (ack_type_in == prl_pkg::ACK_FLUSH_REQ) tx_q.push_back(4);
      end
      if (!srst_in && gap == 0 && tx_q.size() > 0 && (req_ready_in || tx_q[0] == 4)
         && !(burst_open && tx_q[0] < 2)) begin
         v = tx_q.pop_front();
         req_valid_out <= 1'b1;
         req_type_out <= 2'(v / 2);
         req_last_out <= 1'(v % 2);
         if (v / 2 == 1) burst_open <= 1'b1;
         gap <= 4;
      end
   end
endmodule : prl_periph_model

// File: dv/periph_request_length_mgmt_bench.sv
// self-checking bench for prl_periph_req with a peripheral model
// assumes the checker is bound from its own file
`timescale 1ns/1ps
module periph_request_length_mgmt_bench;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic slow = 1'b0;
   logic fin = 1'b0;
   logic cmd_valid = 1'b0;
   logic rvalid = 1'b0;
   logic rlast = 1'b0;
   logic bvalid = 1'b0;
   prl_pkg::prl_cmd_type cmd = '0;
   logic req_valid, req_last, req_ready, ack_valid, ack_ready, done, tflag, lflag;
   logic [1:0] req_type, ack_type;
   int n_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   prl_periph_req #(.FIFO_DEPTH(4)) prl_periph_req_i (.CLK_IN(clk), .SRST_IN(srst),
      .REQ_VALID_IN(req_valid), .REQ_TYPE_IN(req_type), .REQ_LAST_IN(req_last),
      .REQ_READY_OUT(req_ready), .ACK_VALID_OUT(ack_valid), .ACK_TYPE_OUT(ack_type),
      .ACK_READY_IN(ack_ready), .CMD_IN(cmd), .CMD_VALID_IN(cmd_valid), .CMD_DONE_OUT(done),
      .REQ_TYPE_FLAG_OUT(tflag), .REQ_LAST_FLAG_OUT(lflag), .FINAL_SINGLE_IN(fin),
      .RVALID_IN(rvalid), .RREADY_IN(rvalid), .RLAST_IN(rlast), .BVALID_IN(bvalid),
      .BREADY_IN(bvalid));
   prl_periph_model prl_periph_model_i (.clk_in(clk), .srst_in(srst), .slow_in(slow),
      .req_ready_in(req_ready), .ack_valid_in(ack_valid), .ack_type_in(ack_type),
      .req_valid_out(req_valid), .req_type_out(req_type), .req_last_out(req_last),
      .ack_ready_out(ack_ready));
   initial forever #50 clk = ~clk;
   task automatic end_sim;
      if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         end_sim();
      end
   end
   task automatic chk(input logic [1:0] got, input logic [1:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   task automatic send(input int v);
      prl_periph_model_i.tx_q.push_back(v);
   endtask : send
   task automatic ack(input logic [1:0] e);
      chk(prl_periph_model_i.rx_q.size() > 0 ? prl_periph_model_i.rx_q.pop_front() : 2'bxx, e);
   endtask : ack
   // beat: 0 none, 1 read last beat, 2 write response
   task automatic op(input logic [6:0] c, input int beat, input logic f);
      int n;
      @(posedge clk);
      cmd <= c;
      cmd_valid <= 1'b1;
      fin <= f;
      if (beat > 0) begin
         repeat (2 + $urandom_range(3)) @(posedge clk);
         rvalid <= beat == 1;
         rlast <= beat == 1;
         bvalid <= beat == 2;
         @(posedge clk);
         {rvalid, rlast, bvalid} <= 3'h0;
      end
      n = 0;
      while (done !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      chk({1'b0, done}, 2'h1);
      @(posedge clk);
      cmd_valid <= 1'b0;
      fin <= 1'b0;
      @(negedge clk);
   endtask : op
   task automatic wait_ready(input logic r);
      int n;
      n = 0;
      while (req_ready !== r && n < 60) begin
         @(negedge clk);
         n++;
      end
      chk({1'b0, req_ready}, {1'b0, r});
   endtask : wait_ready
   initial begin
      void'($urandom(81));
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      op(7'h02, 0, 1'b0);
      send(4);
      wait_ready(1'b1);
      send(0);
      send(2);
      op(7'h20, 0, 1'b0);
      chk({1'b0, tflag}, 2'h1);
      op(7'h04, 2, 1'b0);
      ack(prl_pkg::ACK_BURST);
      send(1);
      op(7'h10, 0, 1'b0);
      chk({tflag, lflag}, 2'h1);
      op(7'h08, 1, 1'b0);
      ack(prl_pkg::ACK_SINGLE);
      send(0);
      op(7'h50, 0, 1'b0);
      chk({tflag, lflag}, 2'h0);
      send(2);
      op(7'h10, 0, 1'b0);
      chk({1'b0, tflag}, 2'h1);
      op(7'h20, 0, 1'b0);
      send(2);
      op(7'h20, 0, 1'b0);
      slow <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         op(7'h05, 2, i == 3);
         ack(i == 3 ? prl_pkg::ACK_FLUSH_REQ : prl_pkg::ACK_SINGLE);
      end
      wait_ready(1'b0);
      wait_ready(1'b1);
      slow <= 1'b0;
      repeat (4) send(0);
      wait_ready(1'b0);
      op(7'h02, 0, 1'b0);
      send(4);
      wait_ready(1'b1);
      end_sim();
   end
endmodule : periph_request_length_mgmt_bench
